// [hdl/dsp_pkg.sv]
// package of constants and carriers for the debug serial port
// assumes a core on CLK_I and a tool clocking the link on its own clock
package dsp_pkg;

    // ***************************************************
    // frame layout
    // ***************************************************
    localparam int        FRAME_BITS = 35;
    localparam int        SHIFT_BITS = FRAME_BITS - 1;
    localparam logic [5:0] LAST_BIT  = 6'h21;

    localparam logic [1:0] ST_VALID = 2'h0;
    localparam logic [1:0] ST_SEQ   = 2'h1;
    localparam logic [1:0] ST_INT   = 2'h2;
    localparam logic [1:0] ST_NULL  = 2'h3;

    // command field: extended bits then major opcode
    localparam logic [4:0] OP_HRESET = 5'h01;
    localparam logic [4:0] OP_SRESET = 5'h02;
    localparam logic [4:0] OP_DLOAD  = 5'h03;
    localparam logic [4:0] OP_BRKPT  = 5'h1F;
    localparam int         EXT_HI    = 31;
    localparam int         EXT_LO    = 30;
    localparam int         MAJ_HI    = 29;
    localparam int         MAJ_LO    = 25;
    localparam int         TRAP_LO   = 25;
    localparam int         TRAP_BITS = 7;

    // debug register selects
    localparam logic [1:0] SEL_CAUSE  = 2'h0;
    localparam logic [1:0] SEL_ENABLE = 2'h1;
    localparam logic [1:0] SEL_PDATA  = 2'h2;
    localparam logic [31:0] ONES      = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO      = 32'h00000000;

    typedef struct packed {
        logic        mode;
        logic        ctrl;
        logic [31:0] data;
    } dsp_rx_t;

    typedef struct packed {
        logic [1:0]  status;
        logic [31:0] data;
    } dsp_tx_t;

endpackage

// [hdl/dsp_port.sv]
// debug serial port: link shifter, status selection, commands, freeze, protection
// assumes LCLK_I runs while a frame is pending and the core holds its
// inputs synchronous to CLK_I
`timescale 1ns/1ps
module dsp_port (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        LCLK_I,
    input  wire logic        DEBUG_SERIAL_IN_I,
    output logic             DEBUG_SERIAL_OUT_O,
    input  wire logic        DEBUG_EN_I,
    input  wire logic        IN_DEBUG_I,
    input  wire logic        CORE_RD_I,
    input  wire logic        CORE_EXPECT_DATA_I,
    input  wire logic        CORE_INT_I,
    output logic             CORE_INSTR_VALID_O,
    output logic             CORE_DATA_VALID_O,
    output logic [31:0]      CORE_RDATA_O,
    output logic             CORE_BUS_ERR_O,
    output logic             DL_STORE_O,
    output logic [31:0]      DL_DATA_O,
    output logic             DL_ACTIVE_O,
    output logic             HARD_RESET_O,
    output logic             SOFT_RESET_O,
    output logic             MASK_BRK_O,
    output logic             NMASK_BRK_O,
    output logic [6:0]       TRAP_EN_O,
    input  wire logic        SPR_RD_I,
    input  wire logic        SPR_WR_I,
    input  wire logic [1:0]  SPR_SEL_I,
    input  wire logic [31:0] SPR_WDATA_I,
    input  wire logic        USER_PRIVILEGE_BIT_I,
    output logic [31:0]      SPR_RDATA_O,
    output logic             PROG_INT_O,
    input  wire logic [31:0] DBG_EVENT_I,
    input  wire logic        RFI_I,
    output logic             EVENT_IRQ_O,
    output logic             FREEZE_OUT_O
);

    // ***************************************************
    // link domain: 35-bit frame shifter
    // ***************************************************
    logic                 req_s1;
    logic                 req_s2;
    logic                 ack_tgl;
    logic                 busy;
    logic [5:0]           cnt;
    logic [33:0]          sh_out;
    logic [33:0]          sh_in;
    dsp_pkg::dsp_rx_t     rx_hold;
    dsp_pkg::dsp_tx_t     tx_hold;
    logic                 req_tgl;

    wire pend  = req_s2 != ack_tgl;
    wire start = pend && !busy && !DEBUG_SERIAL_OUT_O && DEBUG_SERIAL_IN_I;
    wire last  = busy && cnt == dsp_pkg::LAST_BIT;

    // request toggle crosses in through two flops
    always_ff @(posedge LCLK_I or posedge RST_I) begin
        if (RST_I) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
        end
    end

    // ready low while a frame waits; start bit from tool opens it
    always_ff @(posedge LCLK_I or posedge RST_I) begin
        if (RST_I) begin
            DEBUG_SERIAL_OUT_O <= 1'b1;
        end else if (start) begin
            DEBUG_SERIAL_OUT_O <= tx_hold[33];
        end else if (last) begin
            DEBUG_SERIAL_OUT_O <= 1'b1;
        end else if (busy) begin
            DEBUG_SERIAL_OUT_O <= sh_out[33];
        end else if (pend) begin
            DEBUG_SERIAL_OUT_O <= 1'b0;
        end
    end

    // shift both ways; tx_hold is frozen by the handshake meanwhile
    always_ff @(posedge LCLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy   <= 1'b0;
            cnt    <= 6'h00;
            sh_out <= '0;
            sh_in  <= '0;
        end else if (start) begin
            busy   <= 1'b1;
            cnt    <= 6'h00;
            sh_out <= {tx_hold[32:0], 1'b1};
        end else if (busy) begin
            busy   <= !last;
            cnt    <= cnt + 6'h01;
            sh_out <= {sh_out[32:0], 1'b1};
            sh_in  <= {sh_in[32:0], DEBUG_SERIAL_IN_I};
        end
    end

    // frame end: park received word, answer with ack toggle
    always_ff @(posedge LCLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_tgl <= 1'b0;
            rx_hold <= '0;
        end else if (last) begin
            ack_tgl <= ~ack_tgl;
            rx_hold <= {sh_in[32:0], DEBUG_SERIAL_IN_I};
        end
    end

    // ***************************************************
    // core domain: frame issue and status priority
    // ***************************************************
    typedef enum logic {DSP_IDLE, DSP_WAIT} dsp_state_t;
    dsp_state_t state;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_seen;
    logic       data_pend;
    logic       seq_pend;
    logic       int_pend;
    logic       discard;
    logic       dl_end_pend;
    logic [31:0] pdata;
    logic [31:0] cause;
    logic [31:0] enable;

    wire ack_new = state == DSP_WAIT && ack_s2 != ack_seen;
    wire issue   = state == DSP_IDLE && (CORE_RD_I || DL_ACTIVE_O);

    // priority: data, then sequencing error, then interrupt, then null
    wire [1:0] sel_st = data_pend ? dsp_pkg::ST_VALID :
                        seq_pend  ? dsp_pkg::ST_SEQ :
                        int_pend  ? dsp_pkg::ST_INT :
                                    dsp_pkg::ST_NULL;
    wire [31:0] stat_word = {IN_DEBUG_I, ~DL_ACTIVE_O, dsp_pkg::ONES[29:0]};
    wire [31:0] sel_data  = data_pend ? pdata : stat_word;
    wire        sel_err   = !data_pend && (seq_pend || int_pend);

    // decode of the received frame
    wire        is_core  = !rx_hold.mode;
    wire        is_trap  = rx_hold.mode && !rx_hold.ctrl;
    wire        is_cmd   = rx_hold.mode && rx_hold.ctrl;
    wire        exp_data = DL_ACTIVE_O || CORE_EXPECT_DATA_I;
    wire        mismatch = is_core && (rx_hold.ctrl != exp_data);
    wire        take     = ack_new && !discard;
    wire        seq_hit  = take && mismatch;
    wire        core_ok  = take && is_core && !mismatch;
    wire        deliver  = core_ok && !DL_ACTIVE_O;
    wire        dl_word  = core_ok && DL_ACTIVE_O;
    wire        dl_store = dl_word && !dl_end_pend;
    wire        dl_stop  = dl_word && dl_end_pend;
    wire [1:0]  ext      = rx_hold.data[dsp_pkg::EXT_HI:dsp_pkg::EXT_LO];
    wire [4:0]  major    = rx_hold.data[dsp_pkg::MAJ_HI:dsp_pkg::MAJ_LO];
    wire        cmd      = take && is_cmd;
    wire        cmd_dl   = cmd && major == dsp_pkg::OP_DLOAD && ext[1];
    wire        cmd_brk  = cmd && major == dsp_pkg::OP_BRKPT;

    // debug register access rights
    wire user_acc = (SPR_RD_I || SPR_WR_I) && USER_PRIVILEGE_BIT_I;
    wire sup_rd   = SPR_RD_I && !USER_PRIVILEGE_BIT_I;
    wire sup_wr   = SPR_WR_I && !USER_PRIVILEGE_BIT_I;
    wire locked   = DEBUG_EN_I && !IN_DEBUG_I;
    wire wr_en    = sup_wr && !locked && SPR_SEL_I == dsp_pkg::SEL_ENABLE;
    wire wr_pdata = sup_wr && DEBUG_EN_I && IN_DEBUG_I
                    && SPR_SEL_I == dsp_pkg::SEL_PDATA;
    wire rd_clear = sup_rd && !locked && SPR_SEL_I == dsp_pkg::SEL_CAUSE;

    // sticky flags: a set in the clearing cycle survives
    wire next_data_pend = wr_pdata || (data_pend && !(issue && data_pend));
    wire next_seq_pend  = seq_hit || (seq_pend && !(issue && !data_pend));
    wire next_int_pend  = CORE_INT_I
                          || (int_pend && !(issue && !data_pend && !seq_pend));
    wire [31:0] next_cause = (rd_clear ? dsp_pkg::ZERO : cause) | DBG_EVENT_I;

    // freeze: set by enabled causes while DEBUG_EN_I is low, dropped by return with cause clear
    wire frz_set     = !DEBUG_EN_I && |(cause & enable);
    wire frz_clr     = RFI_I && cause == dsp_pkg::ZERO;
    wire next_freeze = frz_set || (FREEZE_OUT_O && !frz_clr);

    // ack toggle crosses back through two flops
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // one frame in flight; tx_hold written only while link is idle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state    <= DSP_IDLE;
            req_tgl  <= 1'b0;
            ack_seen <= 1'b0;
            tx_hold  <= '0;
            discard  <= 1'b0;
        end else begin
            unique case (state)
                DSP_IDLE: if (issue) begin
                    state   <= DSP_WAIT;
                    req_tgl <= ~req_tgl;
                    tx_hold <= {sel_st, sel_data};
                    discard <= sel_err;
                end
                DSP_WAIT: if (ack_new) begin
                    state    <= DSP_IDLE;
                    ack_seen <= ack_s2;
                end
            endcase
        end
    end

    // pending status flags
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            data_pend <= 1'b0;
            seq_pend  <= 1'b0;
            int_pend  <= 1'b0;
        end else begin
            data_pend <= next_data_pend;
            seq_pend  <= next_seq_pend;
            int_pend  <= next_int_pend;
        end
    end

    // words handed to the core, bus error on wrong frame kind
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CORE_INSTR_VALID_O <= 1'b0;
            CORE_DATA_VALID_O  <= 1'b0;
            CORE_RDATA_O       <= '0;
            CORE_BUS_ERR_O     <= 1'b0;
        end else begin
            CORE_INSTR_VALID_O <= deliver && !rx_hold.ctrl;
            CORE_DATA_VALID_O  <= deliver && rx_hold.ctrl;
            CORE_BUS_ERR_O     <= seq_hit;
            if (deliver) begin
                CORE_RDATA_O <= rx_hold.data;
            end
        end
    end

    // fast download: data words go straight to the store path
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DL_ACTIVE_O <= 1'b0;
            dl_end_pend <= 1'b0;
            DL_STORE_O  <= 1'b0;
            DL_DATA_O   <= '0;
        end else begin
            DL_STORE_O <= dl_store;
            if (dl_store) begin
                DL_DATA_O <= rx_hold.data;
            end
            if (dl_stop) begin
                DL_ACTIVE_O <= 1'b0;
                dl_end_pend <= 1'b0;
            end else if (cmd_dl) begin
                DL_ACTIVE_O <= DL_ACTIVE_O || ext[0];
                dl_end_pend <= DL_ACTIVE_O && !ext[0];
            end
        end
    end

    // debug commands and trap enables
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HARD_RESET_O <= 1'b0;
            SOFT_RESET_O <= 1'b0;
            MASK_BRK_O   <= 1'b0;
            NMASK_BRK_O  <= 1'b0;
            TRAP_EN_O    <= '0;
        end else begin
            HARD_RESET_O <= cmd && major == dsp_pkg::OP_HRESET;
            SOFT_RESET_O <= cmd && major == dsp_pkg::OP_SRESET;
            if (cmd_brk) begin
                MASK_BRK_O  <= ext[0];
                NMASK_BRK_O <= ext[1];
            end
            if (take && is_trap) begin
                TRAP_EN_O <= rx_hold.data[dsp_pkg::TRAP_LO +: dsp_pkg::TRAP_BITS];
            end
        end
    end

    // ***************************************************
    // debug registers, protection and freeze
    // ***************************************************

    // cause write is never honoured; only reads clear it
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cause  <= '0;
            enable <= '0;
            pdata  <= '0;
        end else begin
            cause <= next_cause;
            if (wr_en) begin
                enable <= SPR_WDATA_I;
            end
            if (wr_pdata) begin
                pdata <= SPR_WDATA_I;
            end
        end
    end

    // read data, program interrupt, event interrupts, freeze pin
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SPR_RDATA_O  <= '0;
            PROG_INT_O   <= 1'b0;
            EVENT_IRQ_O  <= 1'b0;
            FREEZE_OUT_O <= 1'b0;
        end else begin
            PROG_INT_O   <= user_acc;
            EVENT_IRQ_O  <= !DEBUG_EN_I && |DBG_EVENT_I;
            FREEZE_OUT_O <= next_freeze;
            if (sup_rd) begin
                SPR_RDATA_O <= SPR_SEL_I == dsp_pkg::SEL_CAUSE  ? cause :
                               SPR_SEL_I == dsp_pkg::SEL_ENABLE ? enable :
                               SPR_SEL_I == dsp_pkg::SEL_PDATA  ? rx_hold.data :
                                                                  dsp_pkg::ZERO;
            end
        end
    end

endmodule

// [bench/dsp_port_checker.sv]
// checker of the debug port core-side pins, core clock domain only
// assumes binding onto dsp_port; link pins are judged by the bench
`timescale 1ns/1ps
module dsp_port_checker (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        DEBUG_EN_I,
    input wire logic [31:0] DBG_EVENT_I,
    input wire logic        RFI_I,
    input wire logic        SPR_RD_I,
    input wire logic        SPR_WR_I,
    input wire logic        USER_PRIVILEGE_BIT_I,
    input wire logic [31:0] SPR_RDATA_O,
    input wire logic        PROG_INT_O,
    input wire logic        FREEZE_OUT_O,
    input wire logic        EVENT_IRQ_O,
    input wire logic        CORE_BUS_ERR_O,
    input wire logic        CORE_INSTR_VALID_O,
    input wire logic        CORE_DATA_VALID_O,
    input wire logic        DL_STORE_O,
    input wire logic        DL_ACTIVE_O,
    input wire logic        HARD_RESET_O
);
    // ***************************************************
    // properties
    // ***************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // user access of any kind, the trapping case
    sequence s_user;
        (SPR_RD_I || SPR_WR_I) && USER_PRIVILEGE_BIT_I;
    endsequence
    // supervisor access of any kind, never trapped
    sequence s_sup;
        (SPR_RD_I || SPR_WR_I) && !USER_PRIVILEGE_BIT_I;
    endsequence
    AST_USER_TRAP: assert property (s_user |=> PROG_INT_O)
        else $error("user access without program interrupt");
    AST_SUP_QUIET: assert property (s_sup |=> !PROG_INT_O)
        else $error("supervisor access raised program interrupt");
    AST_RD_HOLD: assert property (!SPR_RD_I || USER_PRIVILEGE_BIT_I
        |=> $stable(SPR_RDATA_O))
        else $error("read data moved without supervisor read");
    AST_FRZ_HOLD: assert property (FREEZE_OUT_O && !RFI_I |=> FREEZE_OUT_O)
        else $error("freeze dropped without return");
    AST_FRZ_SRC: assert property ($rose(FREEZE_OUT_O) |-> !$past(DEBUG_EN_I))
        else $error("freeze rose with debug enabled");
    AST_IRQ: assert property (!DEBUG_EN_I && DBG_EVENT_I != 32'h00000000
        |-> ##[1:2] EVENT_IRQ_O)
        else $error("event not turned into interrupt");
    AST_ERR_ALONE: assert property (CORE_BUS_ERR_O
        |-> !CORE_INSTR_VALID_O && !CORE_DATA_VALID_O)
        else $error("bus error together with delivery");
    AST_DL_STORE: assert property (DL_STORE_O |-> DL_ACTIVE_O)
        else $error("store outside download");
    AST_DL_END: assert property ($fell(DL_ACTIVE_O) |-> !DL_STORE_O)
        else $error("extra word stored at download end");
    AST_RST_PULSE: assert property (HARD_RESET_O |=> !HARD_RESET_O)
        else $error("hard reset request longer than one cycle");
endmodule
bind dsp_port dsp_port_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .DEBUG_EN_I(DEBUG_EN_I),
    .DBG_EVENT_I(DBG_EVENT_I), .RFI_I(RFI_I), .SPR_RD_I(SPR_RD_I), .SPR_WR_I(SPR_WR_I),
    .USER_PRIVILEGE_BIT_I(USER_PRIVILEGE_BIT_I), .SPR_RDATA_O(SPR_RDATA_O),
    .PROG_INT_O(PROG_INT_O), .FREEZE_OUT_O(FREEZE_OUT_O), .EVENT_IRQ_O(EVENT_IRQ_O),
    .CORE_BUS_ERR_O(CORE_BUS_ERR_O), .CORE_INSTR_VALID_O(CORE_INSTR_VALID_O),
    .CORE_DATA_VALID_O(CORE_DATA_VALID_O), .DL_STORE_O(DL_STORE_O),
    .DL_ACTIVE_O(DL_ACTIVE_O), .HARD_RESET_O(HARD_RESET_O));

// [bench/dsp_tool_model.sv]
// development tool model: shifts 35-bit frames on its own link clock
// assumes the port drives ready low before each frame; clock idles low
`timescale 1ns/1ps
module dsp_tool_model (
    output logic      LCLK_O,
    output logic      SDI_O,
    input  wire logic SDO_I
);
    initial begin
        LCLK_O = 1'b0;
        SDI_O  = 1'b0;
    end
    // one 80 ns link cycle; clock stands still between calls
    task automatic tick();
        #40 LCLK_O = 1'b1;
        #40 LCLK_O = 1'b0;
    endtask
    // frame in msb first, status and word captured one edge behind
    task automatic xfer(input logic [34:0] fin, output logic [33:0] fout, output logic tmo);
        int n;
        n = 0;
        SDI_O = 1'b0;
        while (SDO_I !== 1'b0 && n < 64) begin
            tick();
            n++;
        end
        tmo = (SDO_I !== 1'b0);
        for (int i = 34; i >= 0; i--) begin
            SDI_O = fin[i];
            tick();
            if (i > 0) fout[i-1] = SDO_I;
        end
        SDI_O = ~fin[0]; // released line never repeats the last bit
    endtask
endmodule

// [bench/test_debug_serial_port_protocol.sv]
// self-checking bench of dsp_port with tool model on the link
// assumes the core side is modelled here: reads always pending
`timescale 1ns/1ps
module test_debug_serial_port_protocol;
    logic        CLK_I = 1'b0, RST_I = 1'b1, LCLK_I, SIN, SOUT;
    logic        DEBUG_EN_I = 1'b1, IN_DEBUG_I = 1'b1, CORE_RD_I = 1'b1, CORE_INT_I = 1'b0;
    logic        SPR_RD_I = 1'b0, SPR_WR_I = 1'b0, USER_PRIVILEGE_BIT_I = 1'b0, RFI_I = 1'b0;
    logic        CORE_EXPECT_DATA_I = 1'b0;
    logic [1:0]  SPR_SEL_I = 2'h0;
    logic [31:0] SPR_WDATA_I = 32'h00000000, DBG_EVENT_I = 32'h00000000;
    logic        iv, dv, be, st, dla, hr, sr, mb, nb, pi, irq, freeze_out, tmo, pi_seen;
    logic [31:0] rd, dld, srd;
    logic [6:0]  te;
    logic [33:0] got;
    int          errors = 0, checks = 0, n_iv = 0, n_be = 0, n_st = 0, n_hr = 0, n_sr = 0;
    int          n_dv = 0, n_irq = 0;
    always #2.5 CLK_I = ~CLK_I;
    // pulse tallies of the core side
    always @(posedge CLK_I) begin
        n_iv += (iv === 1'b1);
        n_be += (be === 1'b1);
        n_st += (st === 1'b1);
        n_hr += (hr === 1'b1);
        n_sr += (sr === 1'b1);
        n_dv += (dv === 1'b1);
        n_irq += (irq === 1'b1);
    end
    dsp_tool_model u_tool (.LCLK_O(LCLK_I), .SDI_O(SIN), .SDO_I(SOUT));
    dsp_port DUT (.CLK_I(CLK_I), .RST_I(RST_I), .LCLK_I(LCLK_I), .DEBUG_SERIAL_IN_I(SIN),
        .DEBUG_SERIAL_OUT_O(SOUT), .DEBUG_EN_I(DEBUG_EN_I), .IN_DEBUG_I(IN_DEBUG_I),
        .CORE_RD_I(CORE_RD_I), .CORE_EXPECT_DATA_I(CORE_EXPECT_DATA_I), .CORE_INT_I(CORE_INT_I),
        .CORE_INSTR_VALID_O(iv), .CORE_DATA_VALID_O(dv), .CORE_RDATA_O(rd),
        .CORE_BUS_ERR_O(be), .DL_STORE_O(st), .DL_DATA_O(dld), .DL_ACTIVE_O(dla),
        .HARD_RESET_O(hr), .SOFT_RESET_O(sr), .MASK_BRK_O(mb), .NMASK_BRK_O(nb),
        .TRAP_EN_O(te), .SPR_RD_I(SPR_RD_I), .SPR_WR_I(SPR_WR_I), .SPR_SEL_I(SPR_SEL_I),
        .SPR_WDATA_I(SPR_WDATA_I), .USER_PRIVILEGE_BIT_I(USER_PRIVILEGE_BIT_I),
        .SPR_RDATA_O(srd), .PROG_INT_O(pi), .DBG_EVENT_I(DBG_EVENT_I), .RFI_I(RFI_I),
        .EVENT_IRQ_O(irq), .FREEZE_OUT_O(freeze_out));
    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one frame, then time for the ack to cross and the core to act
    task automatic frame(input logic m, input logic c, input logic [31:0] d);
        u_tool.xfer({1'b1, m, c, d}, got, tmo);
        if (tmo === 1'b1) begin
            errors++;
            finish_test();
        end
        repeat (20) @(negedge CLK_I);
    endtask
    // one-cycle register access; pi sampled in its single cycle
    task automatic spr(input logic r, input logic w, input logic u, input logic [1:0] s,
                       input logic [31:0] d);
        @(negedge CLK_I);
        SPR_RD_I = r;
        SPR_WR_I = w;
        USER_PRIVILEGE_BIT_I = u;
        SPR_SEL_I = s;
        SPR_WDATA_I = d;
        @(negedge CLK_I);
        SPR_RD_I = 1'b0;
        SPR_WR_I = 1'b0;
        pi_seen = pi;
        @(negedge CLK_I);
    endtask
    task automatic pulse_int();
        CORE_INT_I = 1'b1;
        @(negedge CLK_I);
        CORE_INT_I = 1'b0;
    endtask
    task automatic rfi();
        RFI_I = 1'b1;
        @(negedge CLK_I);
        RFI_I = 1'b0;
        repeat (3) @(negedge CLK_I);
    endtask
    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_link();
        check(SOUT, 1'b1);
        frame(1'b0, 1'b0, 32'h12345678);
        check(got, {dsp_pkg::ST_NULL, dsp_pkg::ONES});
        check(n_iv, 1);
        check(rd, 32'h12345678);
        frame(1'b0, 1'b1, 32'hA5A50F0F); // data while instruction expected
        check(n_be, 1);
        pulse_int();
        frame(1'b0, 1'b0, 32'h0BAD0001);
        check(got, {dsp_pkg::ST_SEQ, dsp_pkg::ONES});
        frame(1'b0, 1'b0, 32'h0BAD0002);
        check(got, {dsp_pkg::ST_INT, dsp_pkg::ONES});
        check(n_iv, 1);
        spr(1'b0, 1'b1, 1'b0, dsp_pkg::SEL_PDATA, 32'hC0DE5A5A);
        pulse_int(); // interrupt alongside valid data
        frame(1'b1, 1'b1, 32'h00000000);
        check(got, {dsp_pkg::ST_NULL, dsp_pkg::ONES}); // frame issued before the move
        frame(1'b1, 1'b1, 32'h00000000);
        check(got, {dsp_pkg::ST_VALID, 32'hC0DE5A5A});
        frame(1'b0, 1'b0, 32'h0BAD0003);
        check(got, {dsp_pkg::ST_INT, dsp_pkg::ONES});
        check(n_iv, 1);
    endtask
    // core waiting for data: data delivered, instruction trips an error
    task automatic t_data();
        CORE_EXPECT_DATA_I = 1'b1;
        frame(1'b0, 1'b1, 32'h600DDA7A);
        check({n_dv[3:0], rd}, {4'h1, 32'h600DDA7A});
        frame(1'b0, 1'b0, 32'h1A57C0DE); // instruction while data expected
        check(n_be, 2);
        frame(1'b0, 1'b1, 32'h0BAD0004);
        check(got, {dsp_pkg::ST_SEQ, dsp_pkg::ONES});
        check(n_dv, 1);
        CORE_EXPECT_DATA_I = 1'b0;
    endtask
    task automatic t_cmd();
        frame(1'b1, 1'b0, {7'h55, 25'h0000000});
        check(te, 7'h55);
        frame(1'b1, 1'b1, {2'h1, dsp_pkg::OP_BRKPT, 25'h0000000});
        check({mb, nb}, 2'h2);
        frame(1'b1, 1'b1, {2'h2, dsp_pkg::OP_BRKPT, 25'h0000000});
        check({mb, nb}, 2'h1);
        frame(1'b1, 1'b1, {2'h0, dsp_pkg::OP_HRESET, 25'h0000000});
        frame(1'b1, 1'b1, {2'h0, dsp_pkg::OP_SRESET, 25'h0000000});
        check({n_hr[3:0], n_sr[3:0]}, 8'h11);
        frame(1'b0, 1'b0, 32'h0000FFFC); // pointer preload before download
        check(rd, 32'h0000FFFC);
        frame(1'b1, 1'b1, {2'h3, dsp_pkg::OP_DLOAD, 25'h0000000});
        check(dla, 1'b1);
        frame(1'b0, 1'b1, 32'hDEAD0004);
        check(got, {dsp_pkg::ST_NULL, 2'h2, 30'h3FFFFFFF});
        frame(1'b0, 1'b1, 32'hDEAD0008);
        check(n_st, 2);
        check(dld, 32'hDEAD0008);
        frame(1'b1, 1'b1, {2'h2, dsp_pkg::OP_DLOAD, 25'h0000000});
        frame(1'b0, 1'b1, 32'hDEAD000C);
        check({n_st[3:0], dla}, 5'h04);
    endtask
    task automatic t_regs();
        DEBUG_EN_I = 1'b0;
        spr(1'b0, 1'b1, 1'b0, dsp_pkg::SEL_ENABLE, 32'h00000001);
        spr(1'b0, 1'b1, 1'b1, dsp_pkg::SEL_ENABLE, 32'h000000FF);
        check(pi_seen, 1'b1);
        DEBUG_EN_I = 1'b1;
        IN_DEBUG_I = 1'b0;
        spr(1'b0, 1'b1, 1'b0, dsp_pkg::SEL_ENABLE, 32'h000000F0);
        check(pi_seen, 1'b0);
        spr(1'b1, 1'b0, 1'b0, dsp_pkg::SEL_ENABLE, 32'h00000000);
        check(srd, 32'h00000001);
        DEBUG_EN_I = 1'b0;
        DBG_EVENT_I = 32'h00000001;
        @(negedge CLK_I);
        DBG_EVENT_I = 32'h00000000;
        repeat (4) @(negedge CLK_I);
        check(freeze_out, 1'b1);
        check(n_irq, 1);
        DEBUG_EN_I = 1'b1;
        spr(1'b1, 1'b0, 1'b0, dsp_pkg::SEL_CAUSE, 32'h00000000);
        DEBUG_EN_I = 1'b0;
        rfi();
        check(freeze_out, 1'b1);
        spr(1'b1, 1'b0, 1'b1, dsp_pkg::SEL_CAUSE, 32'h00000000);
        rfi();
        check(freeze_out, 1'b1);
        spr(1'b1, 1'b0, 1'b0, dsp_pkg::SEL_CAUSE, 32'h00000000);
        check(srd, 32'h00000001);
        rfi();
        check(freeze_out, 1'b0);
    endtask
    // main sequence: reset spans link edges too, then the scenarios
    initial begin
        fork
            repeat (2) u_tool.tick();
            repeat (3) @(posedge CLK_I);
        join
        @(negedge CLK_I);
        RST_I = 1'b0;
        t_link();
        t_data();
        t_cmd();
        t_regs();
        finish_test();
    end
endmodule
